// File: src/acdl_params.svh
// Constants of the armature current demand loop: offsets, fields, timing
`ifndef ACDL_PARAMS_SVH
`define ACDL_PARAMS_SVH

// Clock and overload timing
`define ACDL_CLK_MHZ        100
`define ACDL_TICK_US        1000
`define ACDL_US_PER_S       1000000
`define ACDL_OL_PEAK_S      10
`define ACDL_OL_MID_S       60

// Register word indices; byte address is four times the index
`define ACDL_IDX_CTRL       4'h0
`define ACDL_IDX_TORQUE     4'h1
`define ACDL_IDX_AUX        4'h2
`define ACDL_IDX_UPPER      4'h3
`define ACDL_IDX_LOWER      4'h4
`define ACDL_IDX_SCALE      4'h5
`define ACDL_IDX_IMAX       4'h6
`define ACDL_IDX_IMIN       4'h7
`define ACDL_IDX_BKPT1      4'h8
`define ACDL_IDX_BKPT2      4'h9
`define ACDL_IDX_OLTHR      4'hA
`define ACDL_IDX_STOPCEIL   4'hB
`define ACDL_IDX_IRCOMP     4'hC
`define ACDL_IDX_STATUS     4'hD
`define ACDL_IDX_DIAG       4'hE
`define ACDL_IDX_CURFB      4'hF
`define ACDL_NUM_SET        13

// Control and status bit positions
`define ACDL_CTRL_SRC       0
`define ACDL_CTRL_BIPOLAR   1
`define ACDL_CTRL_AVFB      2
`define ACDL_CTRL_MASK      16'h0007
`define ACDL_ST_DISABLED    0
`define ACDL_ST_ATLIMIT     1
`define ACDL_ST_PHASE_LO    2

// Q12 levels, 16'h1000 is 100 percent
`define ACDL_Q_FRAC         12
`define ACDL_Q_200          16'h2000
`define ACDL_Q_150          16'h1800
`define ACDL_Q_MAX          16'h7FFF
`define ACDL_Q_MIN          16'h8000

// Reset values
`define ACDL_RST_CTRL       16'h0002
`define ACDL_RST_UPPER      16'h1000
`define ACDL_RST_LOWER      16'hF000
`define ACDL_RST_SCALE      16'h1000
`define ACDL_RST_IMAX       16'h2000
`define ACDL_RST_IMIN       16'h2000
`define ACDL_RST_BKPT       16'h1000
`define ACDL_RST_OLTHR      16'h119A
`define ACDL_RST_STOPCEIL   16'h1000
`define ACDL_RST_ZERO       16'h0000

`endif

// File: src/acdl_pkg.sv
// Types shared by the current demand loop modules
package acdl_pkg;

  typedef logic signed [15:0] acdl_q_t;

  typedef enum logic [1:0] {
    acdl_ol_peak  = 2'b00,
    acdl_ol_mid   = 2'b01,
    acdl_ol_decay = 2'b10,
    acdl_ol_cont  = 2'b11
  } acdl_ol_e;

endpackage

// File: src/acdl_profile.sv
// Speed dependent current limit profile between two breakpoints
`timescale 1ns/1ps

module acdl_profile (
  input  wire logic [15:0] speed_mag,
  input  wire logic [15:0] imax,
  input  wire logic [15:0] imin,
  input  wire logic [15:0] bkpt1,
  input  wire logic [15:0] bkpt2,
  output logic      [15:0] limit
);

  logic signed [16:0] span;
  logic signed [16:0] offs;
  logic signed [16:0] drop;
  logic signed [33:0] prod;
  logic signed [33:0] cut;
  logic signed [33:0] res;

  // Linear fall from imax at bkpt1 to imin at bkpt2; span is nonzero here
  always_comb
  begin
    span = $signed({1'b0, bkpt2}) - $signed({1'b0, bkpt1});
    offs = $signed({1'b0, speed_mag}) - $signed({1'b0, bkpt1});
    drop = $signed({imax[15], imax}) - $signed({imin[15], imin});
    prod = drop * offs;
    cut  = 34'sd0;
    res  = 34'sd0;
    if (speed_mag <= bkpt1)
    begin
      limit = imax;
    end
    else if (speed_mag >= bkpt2)
    begin
      limit = imin;
    end
    else
    begin
      // Signed divide; a concatenation alone would force unsigned math
      cut = prod / $signed({{17{span[16]}}, span});
      res = $signed({{18{imax[15]}}, imax}) - cut;
      if (res < 34'sd0)
      begin
        limit = 16'h0000;
      end
      else if (res > 34'sh7FFF)
      begin
        limit = 16'h7FFF;
      end
      else
      begin
        limit = res[15:0];
      end
    end
  end

endmodule

// File: src/acdl_top.sv
// Armature current demand selection, limiting, feedback and loop status
//
// The register addresses and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
`include "acdl_params.svh"

module acdl_top #(
  parameter int TICK_CYCLES = `ACDL_TICK_US * `ACDL_CLK_MHZ,
  parameter int PEAK_TICKS  = `ACDL_OL_PEAK_S * (`ACDL_US_PER_S / `ACDL_TICK_US),
  parameter int MID_TICKS   = `ACDL_OL_MID_S * (`ACDL_US_PER_S / `ACDL_TICK_US)
) (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [15:0] speed_reg_out,
  input  wire logic [15:0] speed_feedback,
  input  wire logic [15:0] arm_current,
  input  wire logic [15:0] arm_voltage,
  input  wire logic        loop_inhibit,
  input  wire logic        run_enable,
  input  wire logic        drive_healthy,
  input  wire logic        aux_enable,
  input  wire logic        program_stop,
  output logic      [15:0] current_demand,
  output logic      [15:0] demand_diag,
  output logic      [15:0] current_fb,
  output logic      [15:0] speed_fb_out,
  output logic             loop_disabled,
  output logic             at_limit
);

  localparam int TW = $clog2(TICK_CYCLES + 1);
  localparam int OW = $clog2(PEAK_TICKS + MID_TICKS + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
  localparam logic [OW-1:0] OL_PEAK_END = OW'(PEAK_TICKS);
  localparam logic [OW-1:0] OL_MID_END = OW'(PEAK_TICKS + MID_TICKS);

  // Saturate a wide signed value into Q12
  function automatic logic [15:0] sat16(input logic signed [33:0] v);
    if (v > $signed({{18{1'b0}}, `ACDL_Q_MAX}))
      sat16 = `ACDL_Q_MAX;
    else if (v < $signed({{18{1'b1}}, `ACDL_Q_MIN}))
      sat16 = `ACDL_Q_MIN;
    else
      sat16 = v[15:0];
  endfunction

  // Q12 product with saturation
  function automatic logic [15:0] qmul(input logic [15:0] a,
                                       input logic [15:0] b);
    logic signed [33:0] p;
    p = 34'($signed(a) * $signed(b));
    qmul = sat16(p >>> `ACDL_Q_FRAC);
  endfunction

  // Magnitude, saturated so the most negative code stays positive
  function automatic logic [15:0] mag16(input logic [15:0] a);
    mag16 = a[15] ? sat16(-34'($signed(a))) : a;
  endfunction

  function automatic logic [15:0] neg16(input logic [15:0] a);
    neg16 = sat16(-34'($signed(a)));
  endfunction

  function automatic logic [15:0] smin(input logic [15:0] a,
                                       input logic [15:0] b);
    smin = ($signed(a) < $signed(b)) ? a : b;
  endfunction

  function automatic logic [15:0] smax(input logic [15:0] a,
                                       input logic [15:0] b);
    smax = ($signed(a) > $signed(b)) ? a : b;
  endfunction

  function automatic logic [15:0] rst_val(input int idx);
    case (idx)
      0:       rst_val = `ACDL_RST_CTRL;
      3:       rst_val = `ACDL_RST_UPPER;
      4:       rst_val = `ACDL_RST_LOWER;
      5:       rst_val = `ACDL_RST_SCALE;
      6:       rst_val = `ACDL_RST_IMAX;
      7:       rst_val = `ACDL_RST_IMIN;
      8:       rst_val = `ACDL_RST_BKPT;
      9:       rst_val = `ACDL_RST_BKPT;
      10:      rst_val = `ACDL_RST_OLTHR;
      11:      rst_val = `ACDL_RST_STOPCEIL;
      default: rst_val = `ACDL_RST_ZERO;
    endcase
  endfunction

  logic [15:0]          set_q [0:`ACDL_NUM_SET-1];
  logic                 wait_q;
  logic [31:0]          rdata_q;
  logic [3:0]           widx;
  logic                 bus_go;
  logic [15:0]          sum_q;
  logic [15:0]          dem_q;
  logic [15:0]          diag_q;
  logic [15:0]          fb_q;
  logic [15:0]          spd_q;
  logic                 dis_q;
  logic                 lim_hit_q;
  logic [TW-1:0]        tick_cnt_q;
  logic                 tick;
  logic [OW-1:0]        ol_timer_q;
  logic [15:0]          ol_lim_q;
  acdl_pkg::acdl_ol_e   ol_phase_q;
  acdl_pkg::acdl_ol_e   ol_phase_d;
  logic                 over;
  logic [15:0]          sel_dem;
  logic [15:0]          prof_lim;
  logic [15:0]          pos_lim;
  logic [15:0]          neg_lim;
  logic [15:0]          ctrl;
  logic                 dis_now;

  assign widx    = avs_address[5:2];
  assign bus_go  = (avs_read | avs_write) & wait_q;
  assign ctrl    = set_q[`ACDL_IDX_CTRL];

  // One wait cycle per access; the access completes on the low cycle
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      wait_q <= 1'b1;
    else
      wait_q <= ~bus_go;
  end

  // Setting registers; writes land on the edge where waitrequest is low
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      for (int i = 0; i < `ACDL_NUM_SET; i++)
        set_q[i] <= rst_val(i);
    end
    else if (avs_write && !wait_q && widx < 4'(`ACDL_NUM_SET))
    begin
      if (widx == `ACDL_IDX_CTRL)
        set_q[widx] <= avs_writedata[15:0] & `ACDL_CTRL_MASK;
      else
        set_q[widx] <= avs_writedata[15:0];
    end
  end

  // Read data captured ahead so it stands while waitrequest is low
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      rdata_q <= 32'h00000000;
    else if (bus_go && avs_read)
    begin
      if (widx < 4'(`ACDL_NUM_SET))
        rdata_q <= {16'h0000, set_q[widx]};
      else if (widx == `ACDL_IDX_STATUS)
        rdata_q <= {28'h0000000, ol_phase_q, lim_hit_q, dis_q};
      else if (widx == `ACDL_IDX_DIAG)
        rdata_q <= {16'h0000, diag_q};
      else
        rdata_q <= {16'h0000, fb_q};
    end
  end

  // Demand source: register torque demand or speed regulator output
  assign sel_dem = ctrl[`ACDL_CTRL_SRC] ? set_q[`ACDL_IDX_TORQUE]
                                        : speed_reg_out;

  // Loop status from the inhibit and three enables; inhibit on or any enable off blocks current
  assign dis_now = loop_inhibit | ~run_enable | ~drive_healthy
                 | ~aux_enable;

  // Trimmed demand, diagnostic and status, one register stage
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      sum_q  <= 16'h0000;
      diag_q <= 16'h0000;
      dis_q  <= 1'b1;
    end
    else
    begin
      sum_q  <= sat16(34'($signed(sel_dem))
              + 34'($signed(set_q[`ACDL_IDX_AUX])));
      diag_q <= sel_dem;
      dis_q  <= dis_now;
    end
  end

  // Speed feedback; voltage mode subtracts the resistive drop
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      spd_q <= 16'h0000;
    else if (ctrl[`ACDL_CTRL_AVFB])
      spd_q <= sat16(34'($signed(arm_voltage)) - 34'($signed(
               qmul(arm_current, set_q[`ACDL_IDX_IRCOMP]))));
    else
      spd_q <= speed_feedback;
  end

  // Current feedback shown as magnitude when unipolar
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      fb_q <= 16'h0000;
    else
      fb_q <= ctrl[`ACDL_CTRL_BIPOLAR] ? arm_current
                                       : mag16(arm_current);
  end

  // Profile limit from present speed magnitude
  acdl_profile u_profile (
    .speed_mag (mag16(spd_q)),
    .imax      (set_q[`ACDL_IDX_IMAX]),
    .imin      (set_q[`ACDL_IDX_IMIN]),
    .bkpt1     (set_q[`ACDL_IDX_BKPT1]),
    .bkpt2     (set_q[`ACDL_IDX_BKPT2]),
    .limit     (prof_lim)
  );

  // Combined bounds; a misset lower clamp above upper resolves to upper
  always_comb
  begin
    if (program_stop)
    begin
      pos_lim = set_q[`ACDL_IDX_STOPCEIL];
      neg_lim = neg16(set_q[`ACDL_IDX_STOPCEIL]);
    end
    else
    begin
      pos_lim = smin(smin(qmul(set_q[`ACDL_IDX_UPPER],
                set_q[`ACDL_IDX_SCALE]), prof_lim), ol_lim_q);
      neg_lim = smax(smax(qmul(set_q[`ACDL_IDX_LOWER],
                set_q[`ACDL_IDX_SCALE]), neg16(prof_lim)),
                neg16(ol_lim_q));
    end
    neg_lim = smin(neg_lim, pos_lim); // Crossed bounds: upper wins
  end

  // Limited demand; a disabled loop is held at zero
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dem_q     <= 16'h0000;
      lim_hit_q <= 1'b0;
    end
    else if (dis_q)
    begin
      dem_q     <= 16'h0000;
      lim_hit_q <= 1'b0;
    end
    else if ($signed(sum_q) > $signed(pos_lim))
    begin
      dem_q     <= pos_lim;
      lim_hit_q <= 1'b1;
    end
    else if ($signed(sum_q) < $signed(neg_lim))
    begin
      dem_q     <= neg_lim;
      lim_hit_q <= 1'b1;
    end
    else
    begin
      dem_q     <= sum_q;
      lim_hit_q <= 1'b0;
    end
  end

  // Overload time base; ticks keep the timers narrow
  assign tick = (tick_cnt_q == TICK_LAST);
  assign over = mag16(arm_current) > set_q[`ACDL_IDX_OLTHR];

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      tick_cnt_q <= '0;
    else if (tick)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + 1'b1;
  end

  // Time above threshold charges up, time below discharges
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ol_timer_q <= '0;
    else if (tick && over && ol_timer_q < OL_MID_END)
      ol_timer_q <= ol_timer_q + 1'b1;
    else if (tick && !over && ol_timer_q != '0)
      ol_timer_q <= ol_timer_q - 1'b1;
  end

  always_comb
  begin
    ol_phase_d = ol_phase_q;
    unique case (ol_phase_q)
      acdl_pkg::acdl_ol_peak:
        if (ol_timer_q >= OL_PEAK_END)
          ol_phase_d = acdl_pkg::acdl_ol_mid;
      acdl_pkg::acdl_ol_mid:
        if (ol_timer_q >= OL_MID_END)
          ol_phase_d = acdl_pkg::acdl_ol_decay;
        else if (ol_timer_q < OL_PEAK_END)
          ol_phase_d = acdl_pkg::acdl_ol_peak;
      acdl_pkg::acdl_ol_decay:
        if (ol_timer_q < OL_MID_END)
          ol_phase_d = acdl_pkg::acdl_ol_mid;
        else if (ol_lim_q <= set_q[`ACDL_IDX_OLTHR])
          ol_phase_d = acdl_pkg::acdl_ol_cont;
      acdl_pkg::acdl_ol_cont:
        if (ol_timer_q < OL_MID_END)
          ol_phase_d = acdl_pkg::acdl_ol_mid;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ol_phase_q <= acdl_pkg::acdl_ol_peak;
    else
      ol_phase_q <= ol_phase_d;
  end

  // Overload ceiling; decay walks one step per tick toward threshold
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      ol_lim_q <= `ACDL_Q_200;
    else
    begin
      unique case (ol_phase_d)
        acdl_pkg::acdl_ol_peak:  ol_lim_q <= `ACDL_Q_200;
        acdl_pkg::acdl_ol_mid:   ol_lim_q <= `ACDL_Q_150;
        acdl_pkg::acdl_ol_decay:
          if (tick && ol_lim_q > set_q[`ACDL_IDX_OLTHR])
            ol_lim_q <= ol_lim_q - 1'b1;
        acdl_pkg::acdl_ol_cont:
          ol_lim_q <= set_q[`ACDL_IDX_OLTHR];
      endcase
    end
  end

  // Outputs straight from registers
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign current_demand  = dem_q;
  assign demand_diag     = diag_q;
  assign current_fb      = fb_q;
  assign speed_fb_out    = spd_q;
  assign loop_disabled   = dis_q;
  assign at_limit        = lim_hit_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  property p_diag;
    ##1 demand_diag == $past(ctrl[`ACDL_CTRL_SRC] ?
        set_q[`ACDL_IDX_TORQUE] : speed_reg_out);
  endproperty
  a_diag: assert property (p_diag)
    else $error("diagnostic does not follow selected source");

  property p_disabled;
    ##1 loop_disabled == $past(dis_now);
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("loop disabled status wrong");

  property p_zero_when_off;
    loop_disabled |=> current_demand == 16'h0000;
  endproperty
  a_zero_when_off: assert property (p_zero_when_off)
    else $error("demand not zero while loop disabled");

  property p_stop;
    (program_stop && !loop_disabled) |=> $signed(current_demand) <=
      $signed($past(set_q[`ACDL_IDX_STOPCEIL]));
  endproperty
  a_stop: assert property (p_stop)
    else $error("demand above stop ceiling");

  property p_upper;
    !loop_disabled |=> $signed(current_demand) <= $signed($past(pos_lim));
  endproperty
  a_upper: assert property (p_upper)
    else $error("demand above combined upper bound");

  property p_unipolar;
    !ctrl[`ACDL_CTRL_BIPOLAR] |=> !current_fb[15];
  endproperty
  a_unipolar: assert property (p_unipolar)
    else $error("unipolar feedback went negative");

  property p_avfb;
    ctrl[`ACDL_CTRL_AVFB] |=> speed_fb_out == $past(sat16(
      34'($signed(arm_voltage)) - 34'($signed(
      qmul(arm_current, set_q[`ACDL_IDX_IRCOMP])))));
  endproperty
  a_avfb: assert property (p_avfb)
    else $error("voltage mode speed feedback wrong");

  property p_peak;
    (ol_phase_q == acdl_pkg::acdl_ol_peak) |-> ol_lim_q == `ACDL_Q_200;
  endproperty
  a_peak: assert property (p_peak)
    else $error("overload peak ceiling not 200 percent");

  property p_cont;
    (ol_phase_q == acdl_pkg::acdl_ol_cont) |-> ol_lim_q ==
      $past(set_q[`ACDL_IDX_OLTHR]);
  endproperty
  a_cont: assert property (p_cont)
    else $error("continuous ceiling not at threshold");

  property p_wait_one;
    !avs_waitrequest |=> avs_waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("waitrequest low for more than one cycle");

  c_limit: cover property (!loop_disabled ##1 at_limit);
  c_stop: cover property (program_stop ##1 program_stop && at_limit);
  c_torque: cover property (ctrl[`ACDL_CTRL_SRC] ##1 !loop_disabled);
  c_mid: cover property (ol_phase_q == acdl_pkg::acdl_ol_mid);

endmodule

// File: test/acdl_speed_model.sv
// Speed regulator and feedback measurement stand-in for the demand loop
`timescale 1ns/1ps

module acdl_speed_model (
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [15:0] sr_set,
  input  wire logic [15:0] fb_set,
  input  wire logic [15:0] cur_set,
  input  wire logic [15:0] volt_set,
  input  wire logic        inh_set,
  output logic      [15:0] speed_reg_out,
  output logic      [15:0] speed_feedback,
  output logic      [15:0] arm_current,
  output logic      [15:0] arm_voltage,
  output logic             loop_inhibit
);
  // Values launch just after the edge; current blocked during reset
  always_ff @(posedge clk or negedge rstn)
    if (!rstn)
    begin
      speed_reg_out  <= 16'h0000;
      speed_feedback <= 16'h0000;
      arm_current    <= 16'h0000;
      arm_voltage    <= 16'h0000;
      loop_inhibit   <= 1'b1;
    end
    else
    begin
      speed_reg_out  <= sr_set;
      speed_feedback <= fb_set;
      arm_current    <= cur_set;
      arm_voltage    <= volt_set;
      loop_inhibit   <= inh_set;
    end
endmodule

// File: test/acdl_top_tb_top.sv
// Self-checking bench for the armature current demand loop
`timescale 1ns/1ps

module acdl_top_tb_top;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic [15:0] sr_set = 16'h0, fb_set = 16'h0, cur_set = 16'h0;
  logic [15:0] volt_set = 16'h0;
  logic        inh_set = 1'b1, run_enable = 1'b0, program_stop = 1'b0;
  logic        drive_healthy = 1'b1, aux_enable = 1'b1;
  logic [15:0] sro, sfb, acur, avolt, cdem, diag, cfb, sfo;
  logic        linh, loop_disabled, at_limit;
  int          fails = 0;
  int          n_tests = 0;
  logic [3:0]  ri [8] = '{4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'hA, 4'hB, 4'hD};
  logic [15:0] rv [8] = '{16'h0002, 16'h1000, 16'hF000, 16'h1000,
                          16'h2000, 16'h119A, 16'h1000, 16'h0001};
  logic [15:0] pf [3] = '{16'h0200, 16'h0800, 16'h1000};
  logic [15:0] pe [3] = '{16'h1000, 16'h0E00, 16'h0400};

  // 100 MHz clock
  always #5 clk = ~clk;

  acdl_speed_model i_model (
    .clk(clk), .rstn(rstn), .sr_set(sr_set), .fb_set(fb_set),
    .cur_set(cur_set), .volt_set(volt_set), .inh_set(inh_set),
    .speed_reg_out(sro), .speed_feedback(sfb), .arm_current(acur),
    .arm_voltage(avolt), .loop_inhibit(linh)
  );

  // Short overload counts keep the run brief
  acdl_top #(.TICK_CYCLES(4), .PEAK_TICKS(5), .MID_TICKS(10)) i_dut (
    .clk(clk), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .speed_reg_out(sro),
    .speed_feedback(sfb), .arm_current(acur), .arm_voltage(avolt),
    .loop_inhibit(linh), .run_enable(run_enable),
    .drive_healthy(drive_healthy), .aux_enable(aux_enable),
    .program_stop(program_stop), .current_demand(cdem),
    .demand_diag(diag), .current_fb(cfb), .speed_fb_out(sfo),
    .loop_disabled(loop_disabled), .at_limit(at_limit)
  );

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  // Hold the request until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] idx,
                     input logic [15:0] wd, output logic [31:0] rd);
    @(posedge clk);
    avs_address   <= {idx, 2'b00};
    avs_write     <= wr;
    avs_read      <= !wr;
    avs_writedata <= {16'h0000, wd};
    @(posedge clk);
    // Only the watchdog ends a wait that never completes
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask

  task automatic wr(input logic [3:0] idx, input logic [15:0] d);
    logic [31:0] rd;
    bus(1'b1, idx, d, rd);
  endtask

  task automatic rdchk(input logic [3:0] idx, input logic [15:0] e);
    logic [31:0] rd;
    bus(1'b0, idx, 16'h0000, rd);
    chk(rd, {16'h0000, e});
  endtask

  // Outputs sampled at the edge before their own updates land
  task automatic settle;
    repeat (5) @(posedge clk);
  endtask

  task automatic final_report;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Hang guard, well beyond the overload walk
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    final_report();
  end

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 8; i++)
      rdchk(ri[i], rv[i]);
    wr(4'hD, 16'hFFFF);
    rdchk(4'hD, 16'h0001);
    sr_set <= 16'h0800;
    inh_set <= 1'b0;
    run_enable <= 1'b1;
    settle();
    chk(loop_disabled, 1'b0);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk);
      inh_set <= (i == 0);
      run_enable <= (i != 1);
      drive_healthy <= (i != 2);
      aux_enable <= (i != 3);
      settle();
      chk(loop_disabled, 1'b1);
      chk(cdem, 16'h0000);
      inh_set <= 1'b0;
      run_enable <= 1'b1;
      drive_healthy <= 1'b1;
      aux_enable <= 1'b1;
      settle();
      chk(cdem, 16'h0800);
    end
    chk(diag, 16'h0800);
    wr(4'h2, 16'h0400);
    settle();
    chk(cdem, 16'h0C00);
    wr(4'h2, 16'h0000);
    wr(4'h1, 16'h0300);
    wr(4'h0, 16'h0003);
    settle();
    chk(diag, 16'h0300);
    chk(cdem, 16'h0300);
    wr(4'h1, 16'h1800);
    wr(4'h5, 16'h0800);
    settle();
    chk(cdem, 16'h0800);
    chk(at_limit, 1'b1);
    wr(4'h1, 16'hE800);
    settle();
    chk(cdem, 16'hF800);
    wr(4'h5, 16'h1000);
    wr(4'h1, 16'h1800);
    wr(4'h6, 16'h1800);
    wr(4'h7, 16'h0400);
    wr(4'h8, 16'h0400);
    wr(4'h9, 16'h0C00);
    for (int i = 0; i < 3; i++)
    begin
      fb_set <= pf[i];
      settle();
      chk(cdem, pe[i]);
    end
    fb_set <= 16'h0000;
    wr(4'h6, 16'h2000);
    wr(4'h7, 16'h2000);
    wr(4'hB, 16'h1400);
    program_stop <= 1'b1;
    settle();
    chk(cdem, 16'h1400);
    program_stop <= 1'b0;
    cur_set <= 16'hF800;
    settle();
    chk(cfb, 16'hF800);
    wr(4'h0, 16'h0001);
    settle();
    chk(cfb, 16'h0800);
    wr(4'hC, 16'h0800);
    wr(4'h0, 16'h0005);
    volt_set <= 16'h0C00;
    cur_set <= 16'h0400;
    settle();
    chk(sfo, 16'h0A00);
    wr(4'h0, 16'h0003);
    wr(4'h3, 16'h7FFF);
    wr(4'h1, 16'h3000);
    cur_set <= 16'h3000;
    repeat (8) @(posedge clk);
    chk(cdem, 16'h2000);
    repeat (40) @(posedge clk);
    chk(cdem, 16'h1800);
    repeat (7000) @(posedge clk);
    chk(cdem, 16'h119A);
    rdchk(4'hD, 16'h000E);
    rdchk(4'hE, 16'h3000);
    rdchk(4'hF, 16'h3000);
    final_report();
  end
endmodule
